// >>> rtl/pwc_pkg.sv
// Package: constants for the PWM channel counter and period block
package pwc_pkg;
	localparam int unsigned PWC_CNT_W        = 8;
	localparam logic [7:0]  PWC_CNT_RST      = 8'h00;
	localparam logic [7:0]  PWC_PER_RST      = 8'h00;
	localparam logic [7:0]  PWC_DUTY_RST     = 8'h00;
	localparam logic        PWC_ALIGN_LEFT   = 1'b0;
	localparam logic        PWC_DIR_UP       = 1'b0;
	localparam logic        PWC_DIR_DOWN     = 1'b1;
endpackage

// >>> rtl/pwc_channel.sv
// One PWM channel timebase: counter, buffered period and duty, output
`timescale 1ns/10ps
// Overview of operation
// RL1 - Each channel has its own period register setting its output period.
// RL2 - Period write takes effect at period end or on counter write; the code also loads it at once while the run bit is low.
// RL3 - Counter read returns current count without disturbing operation.
// RL4 - Counter write clears count, sets up, loads buffers, sets output.
// RL5 - Counter holds its value while the channel run bit is low.
// RL6 - On enable, counting resumes from the held counter value.
// RL7 - Disabled channel, period zero written: counter clears next tick.
// RL8 - Counter write while running starts a new period at once.
// RL9 - Counter clears when the effective period ends.
// RL10 - Align select bit zero picks left aligned output.
// RL11 - Left aligned mode counts upward only.
// RL12 - Left aligned: counter equal duty toggles the output flip-flop.
// RL13 - Left aligned: counter equal period resets counter, output, loads.
// RL14 - Left aligned counter runs 0 to period minus 1.
// RL15 - Software writes counter before enabling for a clean waveform.
// RL16 - Center aligned counts up 0 to period then down to 0.
// RL17 - Counter advances exactly one per selected clock tick.
module pwc_channel
	import pwc_pkg::*;
(
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Selected clock source tick, one cycle wide
	input  wire logic                     clk_tick,
	// Control bits
	input  wire logic                     channel_run_bit,
	input  wire logic                     center_align_select,
	input  wire logic                     polarity,
	// Period and duty buffer writes
	input  wire logic                     per_wr,
	input  wire logic [pwc_pkg::PWC_CNT_W-1:0] per_wdata,
	input  wire logic                     duty_wr,
	input  wire logic [pwc_pkg::PWC_CNT_W-1:0] duty_wdata,
	// Counter write strobe, data ignored
	input  wire logic                     cnt_wr,
	// Status
	output logic [pwc_pkg::PWC_CNT_W-1:0] channel_count_reg,
	output logic [pwc_pkg::PWC_CNT_W-1:0] channel_period_reg,
	output logic                          count_dir_ff,
	output logic                          pwm_out
);
	import pwc_pkg::*;

	localparam int W = PWC_CNT_W;

	//----------------------------------------------------------------
	// Buffers and derived events
	//----------------------------------------------------------------
	logic [W-1:0] per_buf_ff;
	logic [W-1:0] duty_buf_ff;
	logic [W-1:0] duty_ff;
	logic [W-1:0] cnt_ff;
	logic         dir_ff;
	logic         out_ff;
	logic         zero_clr_ff;
	logic         step;
	logic         left_end;
	logic         ctr_top;
	logic         ctr_end;
	logic         period_end;

	// Counting only on the selected tick while running
	assign step = clk_tick && channel_run_bit; // RL17 RL5

	// Left aligned period ends at period minus one; zero period ends always
	assign left_end = (channel_period_reg == '0) ||
			  (cnt_ff == channel_period_reg - 8'h01); // RL14
	// Center aligned turns at period and ends back at zero going down
	assign ctr_top = (cnt_ff >= channel_period_reg);
	// Zero period never runs; period one ends at its top count
	assign ctr_end = (channel_period_reg == '0) ||
			 ((cnt_ff <= 8'h01) &&
			  (dir_ff == PWC_DIR_DOWN || ctr_top)); // RL16
	assign period_end = step && ((center_align_select == PWC_ALIGN_LEFT)
			  ? left_end : ctr_end); // RL10

	// Period and duty buffers take software writes at any time
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			per_buf_ff <= PWC_PER_RST;
			duty_buf_ff <= PWC_DUTY_RST;
		end else begin
			if (per_wr) begin
				per_buf_ff <= per_wdata; // RL1
			end
			if (duty_wr) begin
				duty_buf_ff <= duty_wdata;
			end
		end
	end

	// Active registers load from buffers; a disabled channel follows
	// writes at once, since no period is running to be torn
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			channel_period_reg <= PWC_PER_RST;
			duty_ff <= PWC_DUTY_RST;
		end else if (cnt_wr || period_end) begin
			channel_period_reg <= per_buf_ff; // RL2 RL4 RL13
			duty_ff <= duty_buf_ff;
		end else if (!channel_run_bit) begin
			channel_period_reg <= per_wr ? per_wdata : per_buf_ff;
			duty_ff <= duty_wr ? duty_wdata : duty_buf_ff;
		end
	end

	// Pending clear after a zero period write on a stopped channel.
	// A new write wins over a tick in the same cycle: that tick is
	// not yet the next one after the write.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			zero_clr_ff <= 1'b0;
		end else if (per_wr && per_wdata == '0 && !channel_run_bit) begin
			zero_clr_ff <= 1'b1; // RL7
		end else if (cnt_wr || (zero_clr_ff && clk_tick)) begin
			zero_clr_ff <= 1'b0;
		end
	end

	//----------------------------------------------------------------
	// Counter and direction
	//----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= PWC_CNT_RST;
			dir_ff <= PWC_DIR_UP;
		end else if (cnt_wr) begin
			cnt_ff <= PWC_CNT_RST; // RL4 RL8
			dir_ff <= PWC_DIR_UP;
		end else if (zero_clr_ff && clk_tick && !channel_run_bit) begin
			cnt_ff <= PWC_CNT_RST; // RL7
		end else if (period_end) begin
			cnt_ff <= PWC_CNT_RST; // RL9 RL13
			dir_ff <= PWC_DIR_UP;
		end else if (step) begin
			if (center_align_select == PWC_ALIGN_LEFT) begin
				cnt_ff <= cnt_ff + 8'h01; // RL11 RL6
				dir_ff <= PWC_DIR_UP;
			end else if (dir_ff == PWC_DIR_UP && ctr_top) begin
				cnt_ff <= cnt_ff - 8'h01; // RL16
				dir_ff <= PWC_DIR_DOWN;
			end else if (dir_ff == PWC_DIR_UP) begin
				cnt_ff <= cnt_ff + 8'h01; // RL16
			end else begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end

	// Output flip-flop: polarity level at restart, toggled at duty match.
	// Center mode toggles on duty match in both directions.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_ff <= 1'b0;
		end else if (cnt_wr || period_end) begin
			out_ff <= polarity; // RL4 RL13
		end else if (step && cnt_ff == duty_ff) begin
			out_ff <= ~out_ff; // RL12
		end
	end

	// Readback sees the live count; no side effect on reads
	assign channel_count_reg = cnt_ff; // RL3
	assign count_dir_ff = dir_ff;
	assign pwm_out = out_ff;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!channel_run_bit && !cnt_wr && !zero_clr_ff) |=>
			(cnt_ff == $past(cnt_ff));
	endproperty
	a_hold: assert property (p_hold) else $error("count moved"); // RL5

	property p_cwr;
		@(posedge mclk) disable iff (!rst_n)
		cnt_wr |=> (cnt_ff == '0 && dir_ff == PWC_DIR_UP &&
			out_ff == $past(polarity) &&
			channel_period_reg == $past(per_buf_ff));
	endproperty
	a_cwr: assert property (p_cwr) else $error("counter write"); // RL4

	property p_step;
		@(posedge mclk) disable iff (!rst_n)
		(step && !cnt_wr && !period_end &&
		 center_align_select == PWC_ALIGN_LEFT) |=>
			(cnt_ff == $past(cnt_ff) + 8'h01);
	endproperty
	a_step: assert property (p_step) else $error("bad step"); // RL17

	property p_notick;
		@(posedge mclk) disable iff (!rst_n)
		(!clk_tick && !cnt_wr) |=> $stable(cnt_ff);
	endproperty
	a_notick: assert property (p_notick) else $error("no tick"); // RL17

	property p_end;
		@(posedge mclk) disable iff (!rst_n)
		(period_end && !cnt_wr) |=> (cnt_ff == '0 && out_ff == $past(polarity));
	endproperty
	a_end: assert property (p_end) else $error("period end"); // RL13

	property p_buf;
		@(posedge mclk) disable iff (!rst_n)
		(channel_run_bit && !cnt_wr && !period_end) |=>
			$stable(channel_period_reg);
	endproperty
	a_buf: assert property (p_buf) else $error("period tore"); // RL2

	property p_max;
		@(posedge mclk) disable iff (!rst_n)
		(center_align_select == PWC_ALIGN_LEFT && channel_run_bit &&
		 channel_period_reg != '0 && cnt_ff < channel_period_reg) |=>
			(cnt_ff < $past(channel_period_reg) ||
			 !$past(channel_run_bit) || $past(cnt_wr));
	endproperty
	a_max: assert property (p_max) else $error("past period"); // RL14

	property p_duty;
		@(posedge mclk) disable iff (!rst_n)
		(step && cnt_ff == duty_ff && !period_end && !cnt_wr) |=>
			(out_ff != $past(out_ff));
	endproperty
	a_duty: assert property (p_duty) else $error("no toggle"); // RL12

	property p_zero;
		@(posedge mclk) disable iff (!rst_n)
		(zero_clr_ff && clk_tick && !channel_run_bit) |=> (cnt_ff == '0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero clear"); // RL7
endmodule

// >>> test/tb.sv
// Self-checking bench for the PWM channel timebase
`timescale 1ns/10ps
module tb;
	import pwc_pkg::*;
	// ---------------------------------------------------------------
	// Stimulus and observation signals
	// ---------------------------------------------------------------
	logic       mclk, rst_n, clk_tick, run, cas, pol;
	logic       per_wr, duty_wr, cnt_wr;
	logic [7:0] per_wdata, duty_wdata, cnt, per;
	logic       dir, pwm;
	int         err_total, n_checks, cyc;
	pwc_channel i_pwc_channel (.mclk(mclk), .rst_n(rst_n),
		.clk_tick(clk_tick), .channel_run_bit(run),
		.center_align_select(cas), .polarity(pol), .per_wr(per_wr),
		.per_wdata(per_wdata), .duty_wr(duty_wr),
		.duty_wdata(duty_wdata), .cnt_wr(cnt_wr),
		.channel_count_reg(cnt), .channel_period_reg(per),
		.count_dir_ff(dir), .pwm_out(pwm));
	// ---------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Ceiling far above the roughly 90 cycles the tests need
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			end_sim();
		end
	end
	task automatic step();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_total = err_total + 1;
		end
	endtask
	// Each strobe is one cycle, then one idle cycle lets outputs land
	task automatic tick(input int n);
		repeat (n) begin
			clk_tick = 1'b1;
			step();
			clk_tick = 1'b0;
			step();
		end
	endtask
	task automatic wr_cnt();
		cnt_wr = 1'b1;
		step();
		cnt_wr = 1'b0;
		step();
	endtask
	task automatic wr_per(input logic [7:0] v);
		per_wdata = v;
		per_wr = 1'b1;
		step();
		per_wr = 1'b0;
		step();
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	// Period 4, duty 2: toggle at the duty match, restart at count 3
	task automatic t_walk();
		wr_per(8'h04);
		duty_wdata = 8'h02;
		duty_wr = 1'b1;
		step();
		duty_wr = 1'b0;
		wr_cnt();
		chk("cnt", 8'h00, cnt);
		chk("out", 8'h01, {7'h00, pwm});
		chk("dir", 8'h00, {7'h00, dir});
		run = 1'b1;
		repeat (4) step();
		chk("cnt idle", 8'h00, cnt);
		tick(2);
		chk("cnt", 8'h02, cnt);
		chk("out", 8'h01, {7'h00, pwm});
		tick(1);
		chk("out", 8'h00, {7'h00, pwm});
		chk("cnt", 8'h03, cnt);
		tick(1);
		chk("cnt", 8'h00, cnt);
		chk("out", 8'h01, {7'h00, pwm});
		$display("test walk done");
	endtask
	// New period waits for the current period to end
	task automatic t_buffer();
		wr_per(8'h06);
		chk("per", 8'h04, per);
		tick(4);
		chk("per", 8'h06, per);
		chk("cnt", 8'h00, cnt);
		tick(5);
		chk("cnt", 8'h05, cnt);
		chk("dir", 8'h00, {7'h00, dir});
		tick(1);
		chk("cnt", 8'h00, cnt);
		$display("test buffer done");
	endtask
	// Stop holds the count, restart resumes, counter write restarts
	task automatic t_hold();
		tick(2);
		run = 1'b0;
		tick(3);
		chk("cnt held", 8'h02, cnt);
		chk("cnt read", 8'h02, cnt);
		run = 1'b1;
		tick(1);
		chk("cnt resume", 8'h03, cnt);
		pol = 1'b0;
		wr_cnt();
		chk("cnt", 8'h00, cnt);
		chk("out", 8'h00, {7'h00, pwm});
		chk("per", 8'h06, per);
		$display("test hold done");
	endtask
	// Zero period while stopped clears the count on the next tick
	task automatic t_zero();
		tick(3);
		run = 1'b0;
		wr_per(8'h00);
		chk("cnt", 8'h03, cnt);
		tick(1);
		chk("cnt", 8'h00, cnt);
		$display("test zero done");
	endtask
	// Center mode, period 3, duty 2: 0 1 2 3 2 1 then restart
	task automatic t_center();
		cas = 1'b1;
		pol = 1'b1;
		wr_per(8'h03);
		wr_cnt();
		run = 1'b1;
		tick(3);
		chk("cnt", 8'h03, cnt);
		chk("out", 8'h00, {7'h00, pwm});
		tick(1);
		chk("cnt", 8'h02, cnt);
		chk("dir", 8'h01, {7'h00, dir});
		tick(1);
		chk("cnt", 8'h01, cnt);
		chk("out", 8'h01, {7'h00, pwm});
		tick(1);
		chk("cnt", 8'h00, cnt);
		chk("dir", 8'h00, {7'h00, dir});
		$display("test center done");
	endtask
	// Reset in mid-run returns every output to zero
	task automatic t_reset();
		tick(1);
		chk("cnt", 8'h01, cnt);
		rst_n = 1'b0;
		step();
		chk("cnt rst", PWC_CNT_RST, cnt);
		chk("per rst", PWC_PER_RST, per);
		chk("out rst", 8'h00, {7'h00, pwm});
		rst_n = 1'b1;
		step();
		step();
		chk("dir rst", 8'h00, {7'h00, dir});
		chk("cnt idle", PWC_CNT_RST, cnt);
		$display("test reset done");
	endtask
	initial begin
		{rst_n, clk_tick, run, cas, per_wr, duty_wr, cnt_wr} = 7'h00;
		{per_wdata, duty_wdata} = 16'h0000;
		pol = 1'b1;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		step();
		chk("cnt rst", PWC_CNT_RST, cnt);
		chk("per rst", PWC_PER_RST, per);
		t_walk();
		t_buffer();
		t_hold();
		t_zero();
		t_center();
		t_reset();
		end_sim();
	end
endmodule
